//--- rtl/sdcpi_top.sv
// Memory side of a quad-bank synchronous DRAM: command decode, bursts, masks and clock gate states.
`timescale 1ns/1ps

module sdcpi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // sdcpi_fifo

module sdcpi_top #(
    parameter int DATA_W = sdcpi_pkg::DATA_W,
    parameter int ROW_W = sdcpi_pkg::ROW_W,
    parameter int MEM_COL_W = sdcpi_pkg::MEM_COL_W,
    parameter int MEM_ROW_W = sdcpi_pkg::MEM_ROW_W,
    parameter int FIFO_DEPTH = sdcpi_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdcpi_pkg::BANK_W-1:0] bank_select_bits,
    input wire logic [ROW_W-1:0] address_inputs,
    input wire logic [DATA_W/8-1:0] lane_masks,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic [DATA_W/8-1:0] data_lines_oe,
    output sdcpi_pkg::sdcpi_pwr_e power_state,
    output logic [sdcpi_pkg::BANKS-1:0] banks_open,
    output logic burst_busy,
    output logic [sdcpi_pkg::CFG_W-1:0] config_value
);
    import sdcpi_pkg::*;

    localparam int LANES = DATA_W / 8;
    localparam int PIN_W = 5 + BANK_W + ROW_W + LANES + DATA_W;
    localparam int IDX_W = BANK_W + MEM_ROW_W + MEM_COL_W;
    localparam int DEPTH = 1 << IDX_W;

    // Every pin passes two flops before any decode sees it.
    logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
    logic cke_s, cs_s;
    logic [3:0] strobes_s;
    logic [BANK_W-1:0] bank_s;
    logic [ROW_W-1:0] addr_s;
    logic [LANES-1:0] mask_s;
    logic [DATA_W-1:0] din_s;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, address_inputs, lane_masks, data_lines_in};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign {cke_s, strobes_s, bank_s, addr_s, mask_s, din_s} = pin_s2_r;
    assign cs_s = strobes_s[3];

    sdcpi_pwr_e pwr_r, pwr_nxt;
    logic [BANKS-1:0] open_r, open_nxt;
    logic [ROW_W-1:0] row_r [BANKS];
    logic [ROW_W-1:0] row_nxt [BANKS];
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic bst_r, bst_nxt, bwr_r, bwr_nxt, bap_r, bap_nxt, bfull_r, bfull_nxt;
    logic [BANK_W-1:0] bbank_r, bbank_nxt;
    logic [COL_W-1:0] bcol_r, bcol_nxt, wrap_mask;
    logic [COL_W:0] left_r, left_nxt, blen;
    logic run, cmd_en, adv, acc_do, acc_wr;
    logic [BANK_W-1:0] acc_bank;
    logic [COL_W-1:0] acc_col;
    logic [IDX_W-1:0] acc_idx;
    logic fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data, rd_word;
    logic [DATA_W-1:0] mem_r [DEPTH];
    sdcpi_cmd_e cmd;

    // A raised chip select turns every strobe pattern into no operation.
    always_comb begin
        if (cs_s) begin
            cmd = sdcpi_cmd_nop;
        end else begin
            cmd = sdcpi_cmd_e'({1'b0, strobes_s[2:0]});
        end
    end

    assign run = (pwr_r == sdcpi_pw_run) && cke_s;
    assign cmd_en = run;
    // Burst length from the configuration code; the reserved codes act as one location.
    always_comb begin
        case (cfg_r[BL_LSB +: BL_W])
            3'h1: blen = 10'h002;
            3'h2: blen = 10'h004;
            3'h3: blen = 10'h008;
            BL_FULL: blen = FULL_PAGE_LEN;
            default: blen = 10'h001;
        endcase
        wrap_mask = (cfg_r[BL_LSB +: BL_W] == BL_FULL) ? FULL_PAGE_MASK : COL_W'(blen - 10'h001);
    end

    // A read stalls while the buffer is full, so no word is dropped.
    assign adv = run && bst_r && (bwr_r || fifo_in_ready);

    always_comb begin
        pwr_nxt = pwr_r;
        open_nxt = open_r;
        row_nxt = row_r;
        cfg_nxt = cfg_r;
        bst_nxt = bst_r;
        bwr_nxt = bwr_r;
        bap_nxt = bap_r;
        bfull_nxt = bfull_r;
        bbank_nxt = bbank_r;
        bcol_nxt = bcol_r;
        left_nxt = left_r;
        acc_do = 1'b0;
        acc_wr = bwr_r;
        acc_bank = bbank_r;
        acc_col = bcol_r;
        case (pwr_r)
            sdcpi_pw_run: begin
                if (!cke_s) begin
                    if (bst_r) begin
                        pwr_nxt = sdcpi_pw_susp;
                    end else if (open_r != '0) begin
                        pwr_nxt = sdcpi_pw_act_pd;
                    end else if (cmd == sdcpi_cmd_ref) begin
                        pwr_nxt = sdcpi_pw_self;
                    end else if (cmd == sdcpi_cmd_bst) begin
                        pwr_nxt = sdcpi_pw_deep;
                    end else begin
                        pwr_nxt = sdcpi_pw_pre_pd;
                    end
                end
            end
            sdcpi_pw_susp: begin
                if (cke_s) begin
                    pwr_nxt = sdcpi_pw_run;
                end
            end
            default: begin
                // Inputs other than the gate are dropped until exit.
                if (cke_s) begin
                    pwr_nxt = sdcpi_pw_run;
                end
            end
        endcase
        if (adv) begin
            acc_do = 1'b1;
            bcol_nxt = (bcol_r & ~wrap_mask) | ((bcol_r + 1'b1) & wrap_mask);
            if (!bfull_r) begin
                left_nxt = left_r - 1'b1;
                if (left_r == 10'h001) begin
                    bst_nxt = 1'b0;
                    if (bap_r) begin
                        open_nxt[bbank_r] = 1'b0;
                    end
                end
            end
        end
        if (cmd_en) begin
            case (cmd)
                sdcpi_cmd_act: begin
                    open_nxt[bank_s] = 1'b1;
                    row_nxt[bank_s] = addr_s;
                end
                sdcpi_cmd_rd, sdcpi_cmd_wr: begin
                    if (open_r[bank_s] && (cmd == sdcpi_cmd_wr || fifo_in_ready)) begin
                        acc_do = 1'b1;
                        acc_wr = (cmd == sdcpi_cmd_wr);
                        acc_bank = bank_s;
                        acc_col = addr_s[COL_W-1:0];
                        bwr_nxt = acc_wr;
                        bbank_nxt = bank_s;
                        bap_nxt = addr_s[PRE_SEL_BIT];
                        bfull_nxt = (cfg_r[BL_LSB +: BL_W] == BL_FULL);
                        bcol_nxt = (acc_col & ~wrap_mask) | ((acc_col + 1'b1) & wrap_mask);
                        left_nxt = blen - 10'h001;
                        bst_nxt = (blen != 10'h001);
                        if (blen == 10'h001 && addr_s[PRE_SEL_BIT]) begin
                            open_nxt[bank_s] = 1'b0;
                        end
                    end
                end
                sdcpi_cmd_bst: begin
                    bst_nxt = 1'b0;
                end
                sdcpi_cmd_pre: begin
                    if (addr_s[PRE_SEL_BIT]) begin
                        open_nxt = '0;
                        bst_nxt = 1'b0;
                    end else begin
                        open_nxt[bank_s] = 1'b0;
                        if (bank_s == bbank_r) begin
                            bst_nxt = 1'b0;
                        end
                    end
                end
                sdcpi_cmd_lmr: begin
                    // Only the main register is kept; the host keeps all banks idle here.
                    if (bank_s == CFG_MAIN_BANK) begin
                        cfg_nxt = CFG_W'({bank_s, addr_s});
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwr_r <= sdcpi_pw_run;
            open_r <= '0;
            cfg_r <= CFG_RESET;
            bst_r <= 1'b0;
            bwr_r <= 1'b0;
            bap_r <= 1'b0;
            bfull_r <= 1'b0;
            bbank_r <= '0;
            bcol_r <= '0;
            left_r <= '0;
            for (int b = 0; b < BANKS; b++) begin
                row_r[b] <= '0;
            end
        end else begin
            pwr_r <= pwr_nxt;
            open_r <= open_nxt;
            cfg_r <= cfg_nxt;
            bst_r <= bst_nxt;
            bwr_r <= bwr_nxt;
            bap_r <= bap_nxt;
            bfull_r <= bfull_nxt;
            bbank_r <= bbank_nxt;
            bcol_r <= bcol_nxt;
            left_r <= left_nxt;
            row_r <= row_nxt;
        end
    end

    // Storage is a small window of each bank, indexed by bank, low row and low column bits.
    assign acc_idx = {acc_bank, row_r[acc_bank][MEM_ROW_W-1:0], acc_col[MEM_COL_W-1:0]};
    assign rd_word = mem_r[acc_idx];

    generate
        for (genvar e = 0; e < DEPTH; e++) begin : g_entry
            for (genvar l = 0; l < LANES; l++) begin : g_lane
                logic [7:0] byte_nxt;
                always_comb begin
                    byte_nxt = mem_r[e][l*8 +: 8];
                    if (acc_do && acc_wr && acc_idx == IDX_W'(e) && !mask_s[l]) begin
                        byte_nxt = din_s[l*8 +: 8];
                    end
                end
                always_ff @(posedge clock or posedge rst) begin
                    if (rst) begin
                        mem_r[e][l*8 +: 8] <= 8'h00;
                    end else begin
                        mem_r[e][l*8 +: 8] <= byte_nxt;
                    end
                end
            end
        end
    endgenerate

    // The output buffer freezes with the clock gate low, which is what suspends a read.
    sdcpi_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(acc_do && !acc_wr),
        .in_data(rd_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_ready(cke_s),
        .out_data(fifo_out_data)
    );

    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic [LANES-1:0] oe_r, oe_nxt, mask_d1_r;
    logic drive_r, drive_nxt;

    always_comb begin
        dout_nxt = dout_r;
        drive_nxt = drive_r;
        if (cke_s) begin
            drive_nxt = fifo_out_valid;
            if (fifo_out_valid) begin
                dout_nxt = fifo_out_data;
            end
        end
        oe_nxt = {LANES{drive_nxt}} & ~mask_d1_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dout_r <= '0;
            drive_r <= 1'b0;
            oe_r <= '0;
            mask_d1_r <= '0;
        end else begin
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
            oe_r <= oe_nxt;
            mask_d1_r <= mask_s;
        end
    end

    assign data_lines_out = dout_r;
    assign data_lines_oe = oe_r;
    assign power_state = pwr_r;
    assign banks_open = open_r;
    assign burst_busy = bst_r;
    assign config_value = cfg_r;

    chk_mask_hiz: assert property (@(posedge clock) disable iff (rst)
        mask_s[0] |-> ##MASK_LAT !data_lines_oe[0]) else $error("masked lane still driven");
    chk_cs_blocks: assert property (@(posedge clock) disable iff (rst)
        (pwr_r == sdcpi_pw_run && cke_s && cs_s && !bst_r) |=> $stable(open_r) && $stable(cfg_r))
        else $error("command taken with chip select high");
    chk_act_opens: assert property (@(posedge clock) disable iff (rst)
        (cmd_en && cmd == sdcpi_cmd_act) |=> open_r[$past(bank_s)] && row_r[$past(bank_s)] == $past(addr_s))
        else $error("activate did not open row");
    chk_pre_all: assert property (@(posedge clock) disable iff (rst)
        (cmd_en && cmd == sdcpi_cmd_pre && addr_s[PRE_SEL_BIT]) |=> open_r == '0)
        else $error("all-bank precharge left a bank open");
    chk_pre_one: assert property (@(posedge clock) disable iff (rst)
        (cmd_en && cmd == sdcpi_cmd_pre && !addr_s[PRE_SEL_BIT] && !bst_r)
        |=> open_r == ($past(open_r) & ~(BANKS'(1) << $past(bank_s)))) else $error("single precharge wrong bank");
    chk_susp_entry: assert property (@(posedge clock) disable iff (rst)
        (pwr_r == sdcpi_pw_run && !cke_s && bst_r) |=> pwr_r == sdcpi_pw_susp) else $error("no clock suspend");
    chk_pd_ignore: assert property (@(posedge clock) disable iff (rst)
        (pwr_r != sdcpi_pw_run && !cke_s) |=> $stable(open_r) && $stable(cfg_r) && $stable(bcol_r))
        else $error("state moved in low power");
    chk_cfg_load: assert property (@(posedge clock) disable iff (rst)
        (cmd_en && cmd == sdcpi_cmd_lmr && bank_s == CFG_MAIN_BANK) |=> cfg_r == $past(CFG_W'({bank_s, addr_s})))
        else $error("configuration not taken");
    chk_bl4_len: assert property (@(posedge clock) disable iff (rst)
        (cmd_en && cmd == sdcpi_cmd_wr && open_r[bank_s] && cfg_r[2:0] == 3'h2 && !addr_s[PRE_SEL_BIT])
        ##1 (cke_s && cmd == sdcpi_cmd_nop && pwr_r == sdcpi_pw_run) [*3] |=> !bst_r)
        else $error("burst of four wrong length");
    cov_masked_read: cover property (@(posedge clock) disable iff (rst) drive_r && !oe_r[0]);
    cov_self_ref: cover property (@(posedge clock) disable iff (rst) pwr_r == sdcpi_pw_self);
    cov_suspend: cover property (@(posedge clock) disable iff (rst) pwr_r == sdcpi_pw_susp);
    cov_auto_pre: cover property (@(posedge clock) disable iff (rst) adv && bap_r && left_r == 10'h001);
endmodule // sdcpi_top

//--- rtl/sdcpi_pkg.sv
// Constants and types shared by the synchronous DRAM command and pin interface.
package sdcpi_pkg;
    localparam int DATA_W = 16;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int CFG_W = 15;
    localparam int FIFO_DEPTH = 32;
    localparam int MEM_COL_W = 4;
    localparam int MEM_ROW_W = 1;
    localparam int PRE_SEL_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam int MASK_LAT = 2;
    localparam logic [BL_W-1:0] BL_FULL = 3'h7;
    localparam logic [BANK_W-1:0] CFG_MAIN_BANK = 2'h0;
    localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;
    localparam logic [COL_W-1:0] FULL_PAGE_MASK = 9'h1ff;
    localparam logic [COL_W:0] FULL_PAGE_LEN = 10'h200;

    typedef enum logic [3:0] {
        sdcpi_cmd_lmr = 4'h0,
        sdcpi_cmd_ref = 4'h1,
        sdcpi_cmd_pre = 4'h2,
        sdcpi_cmd_act = 4'h3,
        sdcpi_cmd_wr = 4'h4,
        sdcpi_cmd_rd = 4'h5,
        sdcpi_cmd_bst = 4'h6,
        sdcpi_cmd_nop = 4'h7
    } sdcpi_cmd_e;

    typedef enum logic [2:0] {
        sdcpi_pw_run = 3'h0,
        sdcpi_pw_pre_pd = 3'h1,
        sdcpi_pw_act_pd = 3'h2,
        sdcpi_pw_self = 3'h3,
        sdcpi_pw_deep = 3'h4,
        sdcpi_pw_susp = 3'h5
    } sdcpi_pwr_e;
endpackage

//--- verification/sdcpi_host_model.sv
// Host-side controller model that drives the memory pins and the shared data lines.
`timescale 1ns/1ps

module sdcpi_host_model (
    input wire logic clock,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [sdcpi_pkg::BANK_W-1:0] bank_select_bits,
    output logic [sdcpi_pkg::ROW_W-1:0] address_inputs,
    output logic [sdcpi_pkg::DATA_W/8-1:0] lane_masks,
    output logic [sdcpi_pkg::DATA_W-1:0] data_lines_in,
    input wire logic [sdcpi_pkg::DATA_W-1:0] data_lines_out,
    input wire logic [sdcpi_pkg::DATA_W/8-1:0] data_lines_oe
);
    import sdcpi_pkg::*;
    logic drv_r;
    logic [DATA_W-1:0] wd_r;
    logic [DATA_W-1:0] float_r;
    logic [DATA_W-1:0] lane_v;

    // A released line toggles every cycle, so a stale word can never pass for read data.
    assign lane_v = {{8{data_lines_oe[1]}}, {8{data_lines_oe[0]}}};
    assign data_lines_in = drv_r ? wd_r : ((lane_v & data_lines_out) | (~lane_v & float_r));

    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        bank_select_bits = 2'h0;
        address_inputs = 13'h0000;
        lane_masks = 2'h0;
        drv_r = 1'b0;
        wd_r = 16'h0000;
        float_r = 16'h5a5a;
    end

    always @(negedge clock) begin
        float_r <= ~float_r;
    end

    // Pins change on the falling edge only, so every rising edge sees a settled command.
    task automatic issue(input sdcpi_cmd_e cmd, input logic sel, input logic [BANK_W-1:0] ba,
            input logic [ROW_W-1:0] adr, input logic [1:0] msk, input logic drv, input logic [DATA_W-1:0] wd);
        @(negedge clock);
        cs_n = ~sel;
        {ras_n, cas_n, we_n} = cmd[2:0];
        bank_select_bits = ba;
        address_inputs = adr;
        lane_masks = msk;
        drv_r = drv;
        wd_r = wd;
    endtask

    // Called right after a falling edge, so the gate also changes off the sampling edge.
    task automatic gate(input logic v);
        cke = v;
    endtask
endmodule // sdcpi_host_model

//--- verification/sdcpi_top_tb_top.sv
// Self-checking bench for the memory-side command and pin interface.
`timescale 1ns/1ps

module sdcpi_top_tb_top;
    import sdcpi_pkg::*;
    logic clock;
    logic rst;
    logic cke, cs_n, ras_n, cas_n, we_n, burst_busy;
    logic [BANK_W-1:0] bank_select_bits;
    logic [ROW_W-1:0] address_inputs;
    logic [DATA_W/8-1:0] lane_masks, data_lines_oe;
    logic [DATA_W-1:0] data_lines_in, data_lines_out;
    sdcpi_pwr_e power_state;
    logic [BANKS-1:0] banks_open;
    logic [CFG_W-1:0] config_value;
    int fails;
    int compares;

    sdcpi_top sdcpi_top_inst (
        .clock(clock), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select_bits(bank_select_bits), .address_inputs(address_inputs), .lane_masks(lane_masks),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
        .power_state(power_state), .banks_open(banks_open), .burst_busy(burst_busy),
        .config_value(config_value)
    );

    sdcpi_host_model sdcpi_host_model_inst (
        .clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select_bits(bank_select_bits), .address_inputs(address_inputs), .lane_masks(lane_masks),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic complete_run();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_state(input string what, input logic [14:0] exp, input logic [14:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic nops(input int n);
        repeat (n) sdcpi_host_model_inst.issue(sdcpi_cmd_nop, 1'b0, 2'h0, 13'h0, 2'h0, 1'b0, 16'h0);
    endtask

    task automatic cmd(input sdcpi_cmd_e c, input logic [1:0] ba, input logic [12:0] adr, input logic [1:0] msk);
        sdcpi_host_model_inst.issue(c, 1'b1, ba, adr, msk, 1'b0, 16'h0);
    endtask

    // All writes go to bank one; a no-operation slot carries the next burst word.
    task automatic wr(input logic [12:0] col, input logic [1:0] msk, input logic [15:0] wd, input sdcpi_cmd_e c);
        sdcpi_host_model_inst.issue(c, c != sdcpi_cmd_nop, 2'h1, col, msk, 1'b1, wd);
    endtask

    task automatic wait_idle();
        int i = 0;
        while (burst_busy !== 1'b0 && i < 600) begin
            nops(1);
            i++;
        end
        if (i >= 600) begin
            fails++;
            $display("Error burst_busy expected 0 seen %b", burst_busy);
            complete_run();
        end
    endtask

    initial begin
        sdcpi_cmd_e lp_cmd [3];
        sdcpi_pwr_e lp_exp [3];
        fails = 0;
        compares = 0;
        lp_cmd = '{sdcpi_cmd_nop, sdcpi_cmd_ref, sdcpi_cmd_bst};
        lp_exp = '{sdcpi_pw_pre_pd, sdcpi_pw_self, sdcpi_pw_deep};
        rst = 1'b1;
        repeat (10) @(negedge clock);
        check_state("power_state", 15'(sdcpi_pw_run), 15'(power_state));
        check_state("banks_open", 15'h0, 15'(banks_open));
        check_state("config_value", CFG_RESET, config_value);
        check_state("data_lines_oe", 15'h0, 15'(data_lines_oe));
        rst = 1'b0;
        nops(8);
        sdcpi_host_model_inst.issue(sdcpi_cmd_act, 1'b0, 2'h2, 13'h3, 2'h0, 1'b0, 16'h0);
        nops(4);
        check_state("banks_open", 15'h0, 15'(banks_open));
        cmd(sdcpi_cmd_act, 2'h1, 13'h3, 2'h0);
        nops(4);
        check_state("banks_open", 15'h2, 15'(banks_open));
        wr(13'h5, 2'h0, 16'h1234, sdcpi_cmd_wr);
        wr(13'h6, 2'h0, 16'h5566, sdcpi_cmd_wr);
        wr(13'h6, 2'h2, 16'habcd, sdcpi_cmd_wr);
        nops(3);
        cmd(sdcpi_cmd_rd, 2'h1, 13'h5, 2'h0);
        cmd(sdcpi_cmd_rd, 2'h1, 13'h6, 2'h0);
        nops(3);
        check_word("read_col5", 16'h1234, data_lines_out);
        check_state("data_lines_oe", 15'h3, 15'(data_lines_oe));
        nops(1);
        check_word("read_col6", 16'h55cd, data_lines_out);
        cmd(sdcpi_cmd_rd, 2'h1, 13'h5, 2'h1);
        nops(4);
        check_state("data_lines_oe", 15'h2, 15'(data_lines_oe));
        check_word("upper_lane", 16'h0012, {8'h00, data_lines_out[15:8]});
        cmd(sdcpi_cmd_rd, 2'h0, 13'h5, 2'h0);
        nops(5);
        check_state("data_lines_oe", 15'h0, 15'(data_lines_oe));
        cmd(sdcpi_cmd_rd, 2'h1, 13'h405, 2'h0);
        nops(8);
        check_state("banks_open", 15'h0, 15'(banks_open));
        cmd(sdcpi_cmd_lmr, 2'h0, 13'h2, 2'h0);
        nops(4);
        check_state("config_value", 15'h2, config_value);
        cmd(sdcpi_cmd_lmr, 2'h1, 13'h3, 2'h0);
        nops(4);
        check_state("config_value", 15'h2, config_value);
        cmd(sdcpi_cmd_act, 2'h1, 13'h3, 2'h0);
        nops(4);
        wr(13'h8, 2'h0, 16'hb000, sdcpi_cmd_wr);
        for (int i = 1; i < 4; i++) begin
            wr(13'h0, 2'h0, 16'hb000 + 16'(i), sdcpi_cmd_nop);
        end
        nops(4);
        cmd(sdcpi_cmd_rd, 2'h1, 13'ha, 2'h0);
        nops(3);
        for (int i = 0; i < 4; i++) begin
            nops(1);
            check_word("burst_word", 16'hb000 + 16'((i + 2) % 4), data_lines_out);
        end
        wait_idle();
        cmd(sdcpi_cmd_act, 2'h0, 13'h1, 2'h0);
        cmd(sdcpi_cmd_act, 2'h2, 13'h1, 2'h0);
        cmd(sdcpi_cmd_act, 2'h3, 13'h1, 2'h0);
        nops(4);
        check_state("banks_open", 15'hf, 15'(banks_open));
        cmd(sdcpi_cmd_pre, 2'h2, 13'h0, 2'h0);
        nops(4);
        check_state("banks_open", 15'hb, 15'(banks_open));
        cmd(sdcpi_cmd_pre, 2'h2, 13'h400, 2'h0);
        nops(4);
        check_state("banks_open", 15'h0, 15'(banks_open));
        cmd(sdcpi_cmd_lmr, 2'h0, 13'h7, 2'h0);
        nops(4);
        cmd(sdcpi_cmd_act, 2'h1, 13'h3, 2'h0);
        nops(4);
        cmd(sdcpi_cmd_rd, 2'h1, 13'h8, 2'h0);
        nops(5);
        sdcpi_host_model_inst.gate(1'b0);
        nops(6);
        check_state("power_state", 15'(sdcpi_pw_susp), 15'(power_state));
        sdcpi_host_model_inst.gate(1'b1);
        nops(20);
        check_state("burst_busy", 15'h1, 15'(burst_busy));
        cmd(sdcpi_cmd_bst, 2'h0, 13'h0, 2'h0);
        wait_idle();
        check_state("power_state", 15'(sdcpi_pw_run), 15'(power_state));
        sdcpi_host_model_inst.gate(1'b0);
        nops(6);
        check_state("power_state", 15'(sdcpi_pw_act_pd), 15'(power_state));
        sdcpi_host_model_inst.gate(1'b1);
        nops(6);
        check_state("power_state", 15'(sdcpi_pw_run), 15'(power_state));
        cmd(sdcpi_cmd_pre, 2'h0, 13'h400, 2'h0);
        nops(4);
        for (int i = 0; i < 3; i++) begin
            cmd(lp_cmd[i], 2'h0, 13'h0, 2'h0);
            sdcpi_host_model_inst.gate(1'b0);
            nops(6);
            check_state("power_state", 15'(lp_exp[i]), 15'(power_state));
            cmd(sdcpi_cmd_act, 2'h0, 13'h1, 2'h0);
            nops(1);
            sdcpi_host_model_inst.gate(1'b1);
            nops(8);
            check_state("power_state", 15'(sdcpi_pw_run), 15'(power_state));
            check_state("banks_open", 15'h0, 15'(banks_open));
        end
        // A reset in mid-run must close the open row and clear the configuration.
        cmd(sdcpi_cmd_act, 2'h3, 13'h1, 2'h0);
        nops(4);
        check_state("banks_open", 15'h8, 15'(banks_open));
        rst = 1'b1;
        nops(2);
        check_state("banks_open", 15'h0, 15'(banks_open));
        check_state("config_value", CFG_RESET, config_value);
        rst = 1'b0;
        nops(8);
        check_state("power_state", 15'(sdcpi_pw_run), 15'(power_state));
        complete_run();
    end
endmodule // sdcpi_top_tb_top
